// File: verilog/wdu_top.sv
// Watchdog control, timed-access protection and urgent interrupt registers
// Function
// - Power-up flag set at power-on, software clears
// - Urgent input ignored while urgent enable clear
// - Urgent input sets flag; written one forces interrupt if urgent enable is written one too
// - Time-out sets watchdog interrupt flag
// - Watchdog reset sets reset flag, software clears
// - Reset enable arms time-out reset
// - Restart write clears counter, bit self-clears
// - Watchdog interrupt raised when enabled
// - Reset follows time-out by 512 clocks unless restarted
// - External reset loads 1x0x0xx0 pattern
// - Power-on sets power flag, clears reset enable
// - Any reset selects minimum time-out
// - Control bit 7 reads as one
// - Four control bits need open timed window
// - Enable register bit 4, others read high
// - Priority register bit 4, others read high
// - Machine cycle is four clocks
// - Keys AA then 55 open three-cycle window
// - Urgent interrupt ungated by global enable
`timescale 1ns/1ps
module wdu_top #(
  parameter int CNT_W = wdu_pkg::WD_CNT_W,
  parameter int BASE_LOG2 = wdu_pkg::WD_BASE_LOG2
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic ext_rst_i,
  input wire logic urgent_irq_input_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  output logic urgent_irq_o,
  output logic wd_irq_o,
  output logic wd_irq_high_priority_o,
  output logic wd_reset_o,
  output logic timed_access_open_o
);
  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic urg_s1;
    logic urg_s2;
    logic por;
    logic urgent_irq_enable;
    logic urgent_irq_flag;
    logic wd_irq_flag;
    logic wd_reset_flag;
    logic wd_reset_enable;
    logic wd_irq_enable;
    logic wd_irq_high_priority;
    logic [wdu_pkg::SEL_W-1:0] sel;
    logic [7:0] rdata;
  } wdu_top_state_t;

  // Power-on values; every field is a constant
  localparam wdu_top_state_t RST_STATE = '{
    ext_s1: 1'b0,
    ext_s2: 1'b0,
    urg_s1: 1'b0,
    urg_s2: 1'b0,
    por: 1'b1,
    urgent_irq_enable: 1'b0,
    urgent_irq_flag: 1'b0,
    wd_irq_flag: 1'b0,
    wd_reset_flag: 1'b0,
    wd_reset_enable: 1'b0,
    wd_irq_enable: wdu_pkg::IRQ_EN_RST[wdu_pkg::WD_IRQ_BIT],
    wd_irq_high_priority: wdu_pkg::IRQ_PRIO_RST[wdu_pkg::WD_IRQ_BIT],
    sel: wdu_pkg::SEL_MIN,
    rdata: 8'h00
  };

  wdu_top_state_t q, d;

  logic ta_open;
  logic tmo;
  logic wd_rst;
  logic pending;
  logic sync_rst;
  logic wr_ctrl;
  logic wr_prot;
  logic wr_sel;
  logic wr_en;
  logic wr_prio;
  logic restart;

  // Address decode for the hit flag; the read path decodes with its own case
  function automatic logic wdu_hit_f(input logic [7:0] a);
    wdu_hit_f = (a == wdu_pkg::ADDR_TA_KEY) ||
                (a == wdu_pkg::ADDR_WD_CTRL) ||
                (a == wdu_pkg::ADDR_WD_SEL) ||
                (a == wdu_pkg::ADDR_IRQ_EN) ||
                (a == wdu_pkg::ADDR_IRQ_PRIO);
  endfunction : wdu_hit_f

  // Reserved bits of the extended registers read high
  function automatic logic [7:0] wdu_ext_byte_f(input logic [7:0] base, input logic b);
    logic [7:0] v;
    v = base;
    v[wdu_pkg::WD_IRQ_BIT] = b;
    wdu_ext_byte_f = v;
  endfunction : wdu_ext_byte_f

  function automatic logic [7:0] wdu_ctrl_byte_f(input wdu_top_state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[wdu_pkg::CTRL_UNIMPL] = 1'b1;
    v[wdu_pkg::CTRL_POR] = s.por;
    v[wdu_pkg::CTRL_URGENT_IRQ_ENABLE] = s.urgent_irq_enable;
    v[wdu_pkg::CTRL_HPI] = s.urgent_irq_flag;
    v[wdu_pkg::CTRL_WD_IRQ_FLAG] = s.wd_irq_flag;
    v[wdu_pkg::CTRL_WD_RESET_FLAG] = s.wd_reset_flag;
    v[wdu_pkg::CTRL_EWT] = s.wd_reset_enable;
    v[wdu_pkg::CTRL_RWT] = 1'b0;
    wdu_ctrl_byte_f = v;
  endfunction : wdu_ctrl_byte_f

  function automatic logic [7:0] wdu_read_f(input logic [7:0] a, input wdu_top_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      wdu_pkg::ADDR_TA_KEY: v = wdu_pkg::TA_KEY_RD;
      wdu_pkg::ADDR_WD_CTRL: v = wdu_ctrl_byte_f(s);
      wdu_pkg::ADDR_WD_SEL: v[wdu_pkg::SEL_W-1:0] = s.sel;
      wdu_pkg::ADDR_IRQ_EN: v = wdu_ext_byte_f(wdu_pkg::IRQ_EN_RST, s.wd_irq_enable);
      wdu_pkg::ADDR_IRQ_PRIO: v = wdu_ext_byte_f(wdu_pkg::IRQ_PRIO_RST, s.wd_irq_high_priority);
      default: v = 8'h00;
    endcase
    wdu_read_f = v;
  endfunction : wdu_read_f

  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == wdu_pkg::ADDR_WD_CTRL);
  assign wr_prot = wr_ctrl && ta_open;
  assign wr_sel = sfr_wr_i && (sfr_addr_i == wdu_pkg::ADDR_WD_SEL);
  assign wr_en = sfr_wr_i && (sfr_addr_i == wdu_pkg::ADDR_IRQ_EN);
  assign wr_prio = sfr_wr_i && (sfr_addr_i == wdu_pkg::ADDR_IRQ_PRIO);
  // Restart only counts inside the window, and never while a reset is applied
  assign restart = wr_prot && sfr_wdata_i[wdu_pkg::CTRL_RWT] && !sync_rst;
  // External pin reset is a level: it holds the sync state while asserted
  assign sync_rst = q.ext_s2 || wd_rst;

  wdu_ta_gate u_ta_gate (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sync_rst_i(sync_rst),
    .wr_i(sfr_wr_i),
    .addr_i(sfr_addr_i),
    .wdata_i(sfr_wdata_i),
    .open_o(ta_open)
  );

  wdu_wd_timer #(
    .CNT_W(CNT_W),
    .BASE_LOG2(BASE_LOG2)
  ) u_wd_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sync_rst_i(sync_rst),
    .restart_i(restart),
    .rst_en_i(q.wd_reset_enable),
    .sel_i(q.sel),
    .timeout_o(tmo),
    .wd_rst_o(wd_rst),
    .pending_o(pending)
  );

  always_comb begin
    d = q;
    if (ce_i) begin
      // Pin inputs pass two flip-flops before use
      d.ext_s1 = ext_rst_i;
      d.ext_s2 = q.ext_s1;
      d.urg_s1 = urgent_irq_input_i;
      d.urg_s2 = q.urg_s1;
      // Unprotected control bits
      if (wr_ctrl) begin
        d.urgent_irq_enable = sfr_wdata_i[wdu_pkg::CTRL_URGENT_IRQ_ENABLE];
        d.urgent_irq_flag = sfr_wdata_i[wdu_pkg::CTRL_HPI];
        d.wd_reset_flag = sfr_wdata_i[wdu_pkg::CTRL_WD_RESET_FLAG];
      end
      // Protected control bits
      if (wr_prot) begin
        d.por = sfr_wdata_i[wdu_pkg::CTRL_POR];
        d.wd_irq_flag = sfr_wdata_i[wdu_pkg::CTRL_WD_IRQ_FLAG];
        d.wd_reset_enable = sfr_wdata_i[wdu_pkg::CTRL_EWT];
      end
      if (wr_sel) begin
        d.sel = sfr_wdata_i[wdu_pkg::SEL_W-1:0];
      end
      if (wr_en) begin
        d.wd_irq_enable = sfr_wdata_i[wdu_pkg::WD_IRQ_BIT];
      end
      if (wr_prio) begin
        d.wd_irq_high_priority = sfr_wdata_i[wdu_pkg::WD_IRQ_BIT];
      end
      // Hardware sets come after the writes so a clear never hides an event
      if (q.urgent_irq_enable && q.urg_s2) begin
        d.urgent_irq_flag = 1'b1;
      end
      if (tmo) begin
        d.wd_irq_flag = 1'b1;
      end
      // Synchronous reset: ones in the pattern are fixed, x bits untouched
      if (sync_rst) begin
        d.urgent_irq_enable = 1'b0;
        d.wd_irq_flag = 1'b0;
        d.wd_irq_enable = wdu_pkg::IRQ_EN_RST[wdu_pkg::WD_IRQ_BIT];
        d.wd_irq_high_priority = wdu_pkg::IRQ_PRIO_RST[wdu_pkg::WD_IRQ_BIT];
        d.sel = wdu_pkg::SEL_MIN;
      end
      if (wd_rst) begin
        d.wd_reset_flag = 1'b1;
      end
      if (sfr_rd_i) begin
        d.rdata = wdu_read_f(sfr_addr_i, q);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata_o = q.rdata;
  assign sfr_hit_o = wdu_hit_f(sfr_addr_i);
  // No global enable term: the core must not mask this request
  assign urgent_irq_o = q.urgent_irq_enable && q.urgent_irq_flag;
  assign wd_irq_o = q.wd_irq_flag && q.wd_irq_enable;
  assign wd_irq_high_priority_o = q.wd_irq_high_priority;
  assign wd_reset_o = wd_rst;
  assign timed_access_open_o = ta_open;

  default clocking wdu_cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  sequence ctrl_read_s;
    ce_i && sfr_rd_i && sfr_addr_i == wdu_pkg::ADDR_WD_CTRL;
  endsequence

  sequence prot_block_s;
    ce_i && wr_ctrl && !ta_open && !sync_rst && !tmo;
  endsequence

  rd_bit7_a: assert property (ctrl_read_s |=> sfr_rdata_o[7] && !sfr_rdata_o[0])
    else $error("control bit 7 or restart bit read wrong");

  ta_read_a: assert property (
    ce_i && sfr_rd_i && sfr_addr_i == wdu_pkg::ADDR_TA_KEY |=> sfr_rdata_o == 8'hFF
  ) else $error("key register did not read all ones");

  hpi_set_a: assert property (ce_i && q.urgent_irq_enable && q.urg_s2 && !sync_rst |=> q.urgent_irq_flag && urgent_irq_o)
    else $error("urgent input did not set flag");

  hpi_ignore_a: assert property (
    ce_i && !q.urgent_irq_enable && !q.urgent_irq_flag && !wr_ctrl |=> !q.urgent_irq_flag
  ) else $error("urgent input taken while disabled");

  por_hold_a: assert property (
    ce_i && q.por && !wr_prot |=> q.por
  ) else $error("power flag cleared without a write");

  prot_write_a: assert property (
    prot_block_s |=> q.por == $past(q.por) && q.wd_reset_enable == $past(q.wd_reset_enable) && q.wd_irq_flag == $past(q.wd_irq_flag)
  ) else $error("protected bit changed outside window");

  wd_irq_flag_set_a: assert property (ce_i && tmo && !sync_rst |=> q.wd_irq_flag)
    else $error("time-out did not set interrupt flag");

  wd_reset_flag_set_a: assert property (
    ce_i && wd_rst |=> q.wd_reset_flag && !q.urgent_irq_enable && q.sel == 2'h0 && !q.wd_irq_flag
  ) else $error("watchdog reset effects missing");

  pend_cancel_a: assert property (ce_i && restart |=> !pending)
    else $error("restart left a reset pending");

  ext_reg_a: assert property (
    ce_i && sync_rst |=> !q.wd_irq_enable && !q.wd_irq_high_priority && !wd_irq_o
  ) else $error("extended registers not reset");

  wd_irq_a: assert property (ce_i && tmo && q.wd_irq_enable && !sync_rst && !wr_en |=> wd_irq_o)
    else $error("watchdog interrupt not raised");

endmodule : wdu_top

// File: pkg/wdu_pkg.sv
// Constants and types shared by the watchdog and urgent interrupt block
package wdu_pkg;
  // Special function register addresses
  localparam logic [7:0] ADDR_TA_KEY = 8'hC7;
  localparam logic [7:0] ADDR_WD_CTRL = 8'hD8;
  localparam logic [7:0] ADDR_WD_SEL = 8'hD9;
  localparam logic [7:0] ADDR_IRQ_EN = 8'hE8;
  localparam logic [7:0] ADDR_IRQ_PRIO = 8'hF8;
  // Watchdog control field positions
  localparam int CTRL_UNIMPL = 7;
  localparam int CTRL_POR = 6;
  localparam int CTRL_URGENT_IRQ_ENABLE = 5;
  localparam int CTRL_HPI = 4;
  localparam int CTRL_WD_IRQ_FLAG = 3;
  localparam int CTRL_WD_RESET_FLAG = 2;
  localparam int CTRL_EWT = 1;
  localparam int CTRL_RWT = 0;
  // Extended enable and priority registers
  localparam int WD_IRQ_BIT = 4;
  localparam logic [7:0] IRQ_EN_RST = 8'hEF;
  localparam logic [7:0] IRQ_PRIO_RST = 8'hEF;
  // Timed access
  localparam logic [7:0] TA_KEY_FIRST = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND = 8'h55;
  localparam logic [7:0] TA_KEY_RD = 8'hFF;
  localparam int MC_CLKS = 4;
  localparam int TA_WINDOW_MC = 3;
  localparam int TA_WINDOW_CYC = MC_CLKS * TA_WINDOW_MC;
  localparam int TA_WIN_W = 4;
  // Watchdog timing
  localparam int RST_DELAY_CYC = 512;
  localparam int DLY_W = 9;
  localparam int SEL_W = 2;
  localparam logic [SEL_W-1:0] SEL_MIN = 2'h0;
  localparam int SEL_STEP_LOG2 = 3;
  localparam int WD_BASE_LOG2 = 17;
  localparam int WD_CNT_W = 26;
  typedef enum logic [0:0] {
    WDU_TMR_RUN = 1'b0,
    WDU_TMR_PEND = 1'b1
  } wdu_tmr_state_t;
endpackage : wdu_pkg

// File: verilog/wdu_ta_gate.sv
// Timed-access key detector and protected write window
`timescale 1ns/1ps
module wdu_ta_gate (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sync_rst_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic open_o
);
  typedef struct packed {
    logic armed;
    logic [wdu_pkg::TA_WIN_W-1:0] win;
  } wdu_ta_state_t;
  wdu_ta_state_t q, d;
  logic key_wr;
  assign key_wr = wr_i && (addr_i == wdu_pkg::ADDR_TA_KEY);
  always_comb begin
    d = q;
    if (ce_i) begin
      if (sync_rst_i) begin
        d = '0;
      end else begin
        if (q.win != '0) begin
          d.win = q.win - 1'b1;
        end
        // Any other write between the two keys breaks the pair
        if (wr_i) begin
          d.armed = key_wr && (wdata_i == wdu_pkg::TA_KEY_FIRST);
          if (q.armed && key_wr && (wdata_i == wdu_pkg::TA_KEY_SECOND)) begin
            d.win = wdu_pkg::TA_WIN_W'(wdu_pkg::TA_WINDOW_CYC);
          end
        end
      end
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign open_o = (q.win != '0);
  sequence key_first_s;
    ce_i && !sync_rst_i && key_wr && (wdata_i == wdu_pkg::TA_KEY_FIRST);
  endsequence
  sequence key_second_s;
    ce_i && !sync_rst_i && key_wr && (wdata_i == wdu_pkg::TA_KEY_SECOND);
  endsequence
  key_open_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    (key_first_s ##1 key_second_s) or (key_first_s ##1 (!wr_i && !sync_rst_i) ##1 key_second_s)
    |=> open_o && q.win == 4'hC
  ) else $error("key pair did not open a full window");
  win_close_a: assert property (
    @(posedge mclk_i) disable iff (rst_i) ce_i && q.win == 4'h1 && !(q.armed && key_wr) |=> !open_o
  ) else $error("window outlived its count");
endmodule : wdu_ta_gate

// File: verilog/wdu_wd_timer.sv
// Watchdog counter, time-out detection and delayed reset
`timescale 1ns/1ps
module wdu_wd_timer #(
  parameter int CNT_W = wdu_pkg::WD_CNT_W,
  parameter int BASE_LOG2 = wdu_pkg::WD_BASE_LOG2
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sync_rst_i,
  input wire logic restart_i,
  input wire logic rst_en_i,
  input wire logic [wdu_pkg::SEL_W-1:0] sel_i,
  output logic timeout_o,
  output logic wd_rst_o,
  output logic pending_o
);
  localparam logic [wdu_pkg::DLY_W-1:0] DLY_LAST = wdu_pkg::DLY_W'(wdu_pkg::RST_DELAY_CYC - 1);
  typedef struct packed {
    wdu_pkg::wdu_tmr_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [wdu_pkg::DLY_W-1:0] dly;
    logic tmo;
    logic wdr;
  } wdu_tmr_t;
  wdu_tmr_t q, d;
  // Top selection wraps to all ones, so the counter needs no spare bit
  function automatic logic [CNT_W-1:0] wdu_limit_f(input logic [wdu_pkg::SEL_W-1:0] s);
    wdu_limit_f = (CNT_W'(1) << (BASE_LOG2 + wdu_pkg::SEL_STEP_LOG2 * int'(s))) - CNT_W'(1);
  endfunction : wdu_limit_f
  logic hit;
  assign hit = (q.cnt >= wdu_limit_f(sel_i));
  always_comb begin
    d = q;
    d.tmo = 1'b0;
    d.wdr = 1'b0;
    if (ce_i) begin
      if (sync_rst_i || restart_i) begin
        d.cnt = '0;
        d.dly = '0;
        d.st = wdu_pkg::WDU_TMR_RUN;
      end else begin
        d.cnt = q.cnt + 1'b1;
        case (q.st)
          wdu_pkg::WDU_TMR_RUN: begin
            if (hit && rst_en_i) begin
              d.st = wdu_pkg::WDU_TMR_PEND;
              d.dly = '0;
            end
          end
          wdu_pkg::WDU_TMR_PEND: begin
            d.dly = q.dly + 1'b1;
            if (q.dly == DLY_LAST) begin
              d.st = wdu_pkg::WDU_TMR_RUN;
              d.wdr = rst_en_i;
            end
          end
          default: d.st = wdu_pkg::WDU_TMR_RUN;
        endcase
        if (hit) begin
          d.cnt = '0;
          d.tmo = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign timeout_o = q.tmo;
  assign wd_rst_o = q.wdr;
  assign pending_o = (q.st == wdu_pkg::WDU_TMR_PEND);
  dly_fire_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && !sync_rst_i && !restart_i && pending_o && q.dly == 9'h1FF && rst_en_i |=> wd_rst_o
  ) else $error("reset not issued after delay");
  restart_a: assert property (
    @(posedge mclk_i) disable iff (rst_i) ce_i && restart_i |=> !pending_o && q.cnt == '0
  ) else $error("restart did not clear the watchdog");
  arm_a: assert property (
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && !sync_rst_i && !restart_i && !pending_o && hit && rst_en_i |=> pending_o && timeout_o
  ) else $error("time-out with reset enable did not arm");
endmodule : wdu_wd_timer

// File: dv/wdu_core_model.sv
// Processor core model driving the special function register bus
`timescale 1ns/1ps
module wdu_core_model (
  input wire logic mclk_i,
  input wire logic [7:0] sfr_rdata_i,
  output logic [7:0] sfr_addr_o,
  output logic [7:0] sfr_wdata_o,
  output logic sfr_wr_o,
  output logic sfr_rd_o
);
  initial begin
    sfr_addr_o = 8'h00;
    sfr_wdata_o = 8'h00;
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
  end
  // Idle bus shows the inverse of the last address; data lines invert on every release, so after one read following a write they show the last written byte
  task automatic release_bus();
    sfr_wr_o = 1'b0;
    sfr_rd_o = 1'b0;
    sfr_addr_o = ~sfr_addr_o;
    sfr_wdata_o = ~sfr_wdata_o;
  endtask : release_bus
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge mclk_i);
    sfr_addr_o = addr;
    sfr_wdata_o = data;
    sfr_wr_o = 1'b1;
    @(posedge mclk_i);
    @(negedge mclk_i);
    release_bus();
  endtask : sfr_write
  // Data is sampled a cycle late; it stands until the next read anyway
  task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge mclk_i);
    sfr_addr_o = addr;
    sfr_rd_o = 1'b1;
    @(posedge mclk_i);
    @(negedge mclk_i);
    release_bus();
    @(negedge mclk_i);
    data = sfr_rdata_i;
  endtask : sfr_read
  task automatic open_window();
    sfr_write(wdu_pkg::ADDR_TA_KEY, wdu_pkg::TA_KEY_FIRST);
    sfr_write(wdu_pkg::ADDR_TA_KEY, wdu_pkg::TA_KEY_SECOND);
  endtask : open_window
endmodule : wdu_core_model

// File: dv/wdu_top_tb.sv
// Self-checking testbench for the watchdog and urgent interrupt block
`timescale 1ns/1ps
module wdu_top_tb;
  localparam int BASE = 4;
  localparam logic [7:0] CTRL = wdu_pkg::ADDR_WD_CTRL;
  logic mclk;
  logic rst;
  logic ce;
  logic ext_rst;
  logic urg_in;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd_stb;
  logic [7:0] rdata;
  logic hit;
  logic urg_irq;
  logic wd_irq;
  logic wd_prio;
  logic wd_reset;
  logic ta_open;
  logic [7:0] rd;
  int fail_count = 0;
  int n_checks = 0;
  int n_rst = 0;
  int cyc;
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Short base period keeps the minimum-select time-out to 16 clocks
  wdu_top #(.CNT_W(BASE + 9), .BASE_LOG2(BASE)) i_wdu_top (
    .mclk_i(mclk), .rst_i(rst), .ce_i(ce), .ext_rst_i(ext_rst), .urgent_irq_input_i(urg_in),
    .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd_stb), .sfr_rdata_o(rdata),
    .sfr_hit_o(hit), .urgent_irq_o(urg_irq), .wd_irq_o(wd_irq), .wd_irq_high_priority_o(wd_prio),
    .wd_reset_o(wd_reset), .timed_access_open_o(ta_open)
  );
  wdu_core_model i_wdu_core_model (
    .mclk_i(mclk), .sfr_rdata_i(rdata), .sfr_addr_o(addr), .sfr_wdata_o(wdata),
    .sfr_wr_o(wr), .sfr_rd_o(rd_stb)
  );
  always @(negedge mclk) begin
    if (wd_reset === 1'b1) begin
      n_rst++;
    end
  end
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp, input string what);
    i_wdu_core_model.sfr_read(a, rd);
    chk(what, rd & mask, exp);
  endtask : rdc
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    i_wdu_core_model.sfr_write(a, d);
  endtask : wr8
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (8000) @(posedge mclk);
    fail_count++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    ext_rst = 1'b0;
    urg_in = 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    // Wd interrupt flag is masked: the short period sets it at any time
    rdc(CTRL, 8'hF7, 8'hC0, "control after power-on");
    rdc(wdu_pkg::ADDR_WD_SEL, 8'hFF, 8'h00, "select after power-on");
    rdc(wdu_pkg::ADDR_IRQ_EN, 8'hFF, wdu_pkg::IRQ_EN_RST, "enable reg reset");
    rdc(wdu_pkg::ADDR_IRQ_PRIO, 8'hFF, wdu_pkg::IRQ_PRIO_RST, "priority reg reset");
    rdc(wdu_pkg::ADDR_TA_KEY, 8'hFF, wdu_pkg::TA_KEY_RD, "key reads");
    rdc(8'h00, 8'hFF, 8'h00, "unmapped read");
    chk("address decode", {7'h00, hit}, 8'h00);
    wr8(CTRL, 8'h22);
    rdc(CTRL, 8'hF7, 8'hE0, "protected bits without window");
    wr8(wdu_pkg::ADDR_TA_KEY, wdu_pkg::TA_KEY_SECOND);
    chk("lone second key", {7'h00, ta_open}, 8'h00);
    i_wdu_core_model.open_window();
    chk("window opened", {7'h00, ta_open}, 8'h01);
    wr8(CTRL, 8'h20);
    rdc(CTRL, 8'hF7, 8'hA0, "power flag cleared in window");
    i_wdu_core_model.open_window();
    repeat (wdu_pkg::TA_WINDOW_CYC - 1) @(posedge mclk);
    @(negedge mclk);
    chk("window last cycle", {7'h00, ta_open}, 8'h01);
    @(negedge mclk);
    chk("window closed", {7'h00, ta_open}, 8'h00);
    wr8(CTRL, 8'h60);
    rdc(CTRL, 8'hF7, 8'hA0, "power flag after window");
    wr8(CTRL, 8'h00);
    urg_in = 1'b1;
    repeat (4) @(negedge mclk);
    rdc(CTRL, 8'hF7, 8'h80, "urgent input ignored");
    chk("urgent irq off", {7'h00, urg_irq}, 8'h00);
    wr8(CTRL, 8'h20);
    repeat (4) @(negedge mclk);
    rdc(CTRL, 8'hF7, 8'hB0, "urgent flag set");
    chk("urgent irq on", {7'h00, urg_irq}, 8'h01);
    urg_in = 1'b0;
    repeat (4) @(negedge mclk);
    rdc(CTRL, 8'hF7, 8'hB0, "urgent flag kept");
    wr8(CTRL, 8'h20);
    rdc(CTRL, 8'hF7, 8'hA0, "urgent flag cleared");
    chk("urgent irq cleared", {7'h00, urg_irq}, 8'h00);
    wr8(CTRL, 8'h30);
    @(negedge mclk);
    chk("urgent irq forced", {7'h00, urg_irq}, 8'h01);
    wr8(CTRL, 8'h20);
    wr8(wdu_pkg::ADDR_IRQ_EN, 8'h00);
    rdc(wdu_pkg::ADDR_IRQ_EN, 8'hFF, 8'hEF, "enable reserved high");
    repeat (2 ** BASE + 8) @(negedge mclk);
    chk("wd irq masked", {7'h00, wd_irq}, 8'h00);
    rdc(CTRL, 8'h08, 8'h08, "time-out recorded");
    wr8(wdu_pkg::ADDR_IRQ_EN, 8'hFF);
    rdc(wdu_pkg::ADDR_IRQ_EN, 8'hFF, 8'hFF, "enable set");
    chk("wd irq raised", {7'h00, wd_irq}, 8'h01);
    wr8(wdu_pkg::ADDR_IRQ_PRIO, 8'h10);
    rdc(wdu_pkg::ADDR_IRQ_PRIO, 8'hFF, 8'hFF, "priority set");
    chk("priority out", {7'h00, wd_prio}, 8'h01);
    wr8(wdu_pkg::ADDR_IRQ_PRIO, 8'h00);
    rdc(wdu_pkg::ADDR_IRQ_PRIO, 8'hFF, 8'hEF, "priority reserved high");
    chk("priority out low", {7'h00, wd_prio}, 8'h00);
    i_wdu_core_model.open_window();
    wr8(CTRL, 8'h23);
    cyc = 0;
    while (n_rst == 0 && cyc < 1000) begin
      @(negedge mclk);
      cyc++;
    end
    chk("reset delay", {7'h00, cyc >= wdu_pkg::RST_DELAY_CYC && cyc <= wdu_pkg::RST_DELAY_CYC + 2 ** BASE + 8},
        8'h01);
    repeat (2) @(negedge mclk);
    rdc(CTRL, 8'hF7, 8'h86, "control after wd reset");
    rdc(wdu_pkg::ADDR_IRQ_EN, 8'hFF, 8'hEF, "enable after wd reset");
    // Restarts spaced wider than one period but inside the reset delay
    repeat (4) begin
      repeat (200) @(posedge mclk);
      i_wdu_core_model.open_window();
      wr8(CTRL, 8'h03);
    end
    chk("reset cancelled", n_rst[7:0], 8'h01);
    rdc(CTRL, 8'h01, 8'h00, "restart self-clears");
    i_wdu_core_model.open_window();
    wr8(CTRL, 8'h00);
    rdc(CTRL, 8'hF7, 8'h80, "flags cleared");
    repeat (600) @(posedge mclk);
    chk("no reset when disarmed", n_rst[7:0], 8'h01);
    wr8(wdu_pkg::ADDR_WD_SEL, 8'h03);
    rdc(wdu_pkg::ADDR_WD_SEL, 8'hFF, 8'h03, "select written");
    wr8(CTRL, 8'h30);
    wr8(wdu_pkg::ADDR_IRQ_PRIO, 8'hFF);
    ext_rst = 1'b1;
    repeat (4) @(negedge mclk);
    ext_rst = 1'b0;
    repeat (4) @(negedge mclk);
    rdc(CTRL, 8'hF7, 8'h90, "control after ext reset");
    rdc(wdu_pkg::ADDR_WD_SEL, 8'hFF, 8'h00, "select after ext reset");
    rdc(wdu_pkg::ADDR_IRQ_EN, 8'hFF, 8'hEF, "enable after ext reset");
    rdc(wdu_pkg::ADDR_IRQ_PRIO, 8'hFF, 8'hEF, "priority after ext reset");
    test_done();
  end
endmodule : wdu_top_tb
